// [shared/dxcr_pkg.sv]
package dxcr_pkg;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [7:0] IDX_CURSOR_COLOR1_C = 8'h2f; // Cursor colour 1 part C
    localparam logic [7:0] IDX_CURSOR_LOC_0 = 8'h30; // Cursor location byte 0
    localparam logic [7:0] IDX_CURSOR_LOC_1 = 8'h31; // Cursor location byte 1
    localparam logic [7:0] IDX_CURSOR_LOC_2 = 8'h32; // Cursor location byte 2
    localparam logic [7:0] IDX_URGENCY_START = 8'h33; // Fetch urgency start
    localparam logic [7:0] IDX_LINE_OFS_LO = 8'h34; // Frame line offset low
    localparam logic [7:0] IDX_LINE_OFS_HI = 8'h35; // Frame line offset high
    localparam logic [7:0] IDX_HALF_FIELD = 8'h39; // Half-field start
    localparam logic [7:0] IDX_IMPL_ID = 8'h3a; // Implementation id
    localparam logic [7:0] IDX_VERSION_ID = 8'h3b; // Version id
    localparam logic [7:0] IDX_DRAM_TIMING = 8'h3c; // DRAM timing
    localparam logic [7:0] IDX_ARB_0 = 8'h3d; // Arbitration 0
    localparam logic [7:0] IDX_ARB_1 = 8'h3e; // Arbitration 1
    localparam logic [7:0] IDX_LINK_PINS = 8'h3f; // Monitor link pins
    localparam logic [7:0] IDX_TV_CTRL = 8'h40; // TV output control

    // ****************************************
    // Reset values and identifiers
    // ****************************************
    localparam logic [7:0] RST_HALF_FIELD = 8'hff; // Interlace off
    localparam logic [7:0] RST_DRAM_TIMING = 8'h00; // FPM, template 0
    localparam logic [7:0] RST_LINK_PINS = 8'hff; // Drivers released
    localparam logic [7:0] RST_ZERO = 8'h00; // Plain cleared value
    localparam logic [7:0] HALF_FIELD_OFF = 8'hff; // Interlace disable code
    localparam logic [7:0] IMPL_ID_VALUE = 8'h5a; // Arbitrary value
    localparam logic [7:0] VERSION_ID_VALUE = 8'h3c; // Arbitrary value

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MEM_TYPE_HI = 7; // Memory type msb
    localparam int MEM_TYPE_LO = 6; // Memory type lsb
    localparam int TEMPLATE_HI = 5; // Template msb
    localparam int TEMPLATE_LO = 3; // Template lsb
    localparam int CAS_WIDE_BIT = 2; // CAS width select
    localparam int TURN_BIT = 1; // EDO read-write turnaround
    localparam int ROW_REL_BIT = 0; // Row strobe release
    localparam int LINK_WR_HI = 7; // Link write data msb
    localparam int LINK_WR_LO = 6; // Link write data lsb
    localparam int LINK_RD_HI = 5; // Link read data msb
    localparam int LINK_RD_LO = 4; // Link read data lsb
    localparam int TV_EN_BIT = 7; // TV enable
    localparam int TV_CODES_BIT = 6; // Timing code insertion
    localparam int TV_SRC_N_BIT = 5; // Video select, active low
    localparam int TV_FIELD_OE_BIT = 4; // Field pin output enable
    localparam int TV_SYNC_OE_BIT = 3; // Line sync output enable
    localparam int FLICK_LUMA_BIT = 2; // Luma-only filtering
    localparam int FLICK_HI = 1; // Filter kind msb
    localparam int FLICK_LO = 0; // Filter kind lsb

    // Memory type codes
    localparam logic [1:0] MEM_FPM = 2'h0; // Fast page mode
    localparam logic [1:0] MEM_EDO = 2'h1; // Extended data out

    // ****************************************
    // Timing templates, in quarter clocks; turnaround in clocks
    // ****************************************
    localparam logic [3:0] CAS_NARROW_Q = 4'h2; // 0.5 clock
    localparam logic [3:0] CAS_WIDE_Q = 4'h3; // 0.75 clock
    localparam logic [1:0] TURN_SHORT = 2'h1; // 1 clock delay
    localparam logic [1:0] TURN_LONG = 2'h2; // 2 clock delay
    localparam logic [3:0] T_CAS_RAS_Q = 4'h2; // 0.5 clock
    localparam logic [3:0] T_PRE_A_Q = 4'h6; // 1.5 clocks
    localparam logic [3:0] T_PRE_B_Q = 4'h8; // 2.0 clocks

    // ****************************************
    // Enumerations and carriers
    // ****************************************
    typedef enum logic [1:0] {
        DXCR_PIN_IN,
        DXCR_PIN_VIDEO,
        DXCR_PIN_TV
    } dxcr_pin_src_e;

    typedef enum logic [1:0] {
        DXCR_FLT_OFF,
        DXCR_FLT_011,
        DXCR_FLT_121,
        DXCR_FLT_131
    } dxcr_flt_e;

    // Register bank contents
    typedef struct packed {
        logic [7:0] cursor_color1_c;
        logic [7:0] cursor_loc_0;
        logic [7:0] cursor_loc_1;
        logic [7:0] cursor_loc_2;
        logic [7:0] urgency_start;
        logic [7:0] line_ofs_lo;
        logic [7:0] line_ofs_hi;
        logic [7:0] half_field;
        logic [7:0] dram_timing;
        logic [7:0] arb_0;
        logic [7:0] arb_1;
        logic [7:0] link_pins;
        logic [7:0] tv_ctrl;
    } dxcr_regs_s;

    // Whole module state
    typedef struct packed {
        dxcr_regs_s regs;
        logic [7:0] rdata;
        logic urgent_win;
        logic fetch_urgent;
        logic [1:0] link_meta;
        logic [1:0] link_sync;
    } dxcr_state_s;

    // DRAM controller settings
    typedef struct packed {
        logic [1:0] mem_type;
        logic [3:0] cas_to_ras_q;
        logic [3:0] precharge_q;
        logic [3:0] ras_to_cas_q;
        logic [3:0] cas_width_q;
        logic [1:0] turnaround;
        logic row_release;
    } dxcr_dram_s;

    // TV output settings
    typedef struct packed {
        logic enable;
        logic timing_codes;
        logic from_graphics;
        dxcr_pin_src_e field_src;
        dxcr_pin_src_e sync_src;
        dxcr_flt_e filter;
        logic luma_only;
    } dxcr_tv_s;

endpackage

// [rtl/dxcr_regs.sv]
// What this block does
// - Fetches low priority before urgent start position
// - Urgent fetch at start when FIFO low
// - Afterward urgent whenever FIFO low until disable
// - Two bytes form signed 16-bit line offset
// - Odd frames clock vertical at half-field count
// - Half-field all ones disables interlace, reset
// - Two read-only implementation and version identifiers
// - Memory type 00 FPM, 01 EDO
// - Template lsb sets RAS/CAS intervals; upper two bits unused
// - CAS width bit: 0.5 or 0.75 clock
// - EDO turnaround bit: one or two clocks
// - Row release bit; timing register resets zero
// - Link write bits drive open-collector pins
// - Write bits read back; separate pin levels
// - TV pixel output works only when enabled
// - Codes bit inserts timing reference codes when enabled
// - Active-low select routes graphics or video
// - Field pin direction from two bits
// - Line sync pin direction likewise
// - Two-bit anti-flicker filter selection, plus luma-only bit
module dxcr_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic [7:0] hchar_count,
    input wire logic display_enable,
    input wire logic fifo_below_low,
    input wire logic odd_frame,
    output logic fetch_urgent,
    output logic vert_clock_tick,
    output logic interlace_on,
    output logic [15:0] frame_line_offset,
    output dxcr_pkg::dxcr_dram_s dram_cfg,
    output logic [1:0] link_pin_o,
    output logic [1:0] link_pin_oe,
    input wire logic [1:0] link_pin_i,
    output dxcr_pkg::dxcr_tv_s tv_cfg,
    input wire logic video_field_dir,
    input wire logic video_sync_dir,
    input wire logic tv_field_gen,
    input wire logic tv_sync_gen,
    input wire logic video_field_gen,
    input wire logic video_sync_gen,
    output logic field_parity_pin_o,
    output logic field_parity_pin_oe,
    output logic tv_line_sync_pin_o,
    output logic tv_line_sync_pin_oe,
    input wire logic [15:0] gfx_pixel,
    input wire logic [15:0] video_pixel,
    output logic [15:0] tv_pixel
);

    // ****************************************
    // State
    // ****************************************
    dxcr_pkg::dxcr_state_s s_q; // Registered state
    dxcr_pkg::dxcr_state_s s_d; // Next state
    logic [1:0] mem_sel; // Memory type field
    logic [2:0] tmpl; // Timing template field
    dxcr_pkg::dxcr_pin_src_e field_src; // Field pin source
    dxcr_pkg::dxcr_pin_src_e sync_src; // Line sync pin source

    // ****************************************
    // Next-state logic
    // ****************************************
    // All state advances together; clock enable freezes everything
    always_comb begin
        s_d = s_q;
        // Pin levels cross in through two flops before use
        s_d.link_meta = link_pin_i;
        s_d.link_sync = s_q.link_meta;
        // Register writes; identifiers have no storage
        if (reg_wr) begin
            case (reg_index)
                dxcr_pkg::IDX_CURSOR_COLOR1_C: s_d.regs.cursor_color1_c = reg_wdata;
                dxcr_pkg::IDX_CURSOR_LOC_0: s_d.regs.cursor_loc_0 = reg_wdata;
                dxcr_pkg::IDX_CURSOR_LOC_1: s_d.regs.cursor_loc_1 = reg_wdata;
                dxcr_pkg::IDX_CURSOR_LOC_2: s_d.regs.cursor_loc_2 = reg_wdata;
                dxcr_pkg::IDX_URGENCY_START: s_d.regs.urgency_start = reg_wdata;
                dxcr_pkg::IDX_LINE_OFS_LO: s_d.regs.line_ofs_lo = reg_wdata;
                dxcr_pkg::IDX_LINE_OFS_HI: s_d.regs.line_ofs_hi = reg_wdata;
                dxcr_pkg::IDX_HALF_FIELD: s_d.regs.half_field = reg_wdata;
                dxcr_pkg::IDX_DRAM_TIMING: s_d.regs.dram_timing = reg_wdata;
                // Stored as written; software keeps these zero
                dxcr_pkg::IDX_ARB_0: s_d.regs.arb_0 = reg_wdata;
                dxcr_pkg::IDX_ARB_1: s_d.regs.arb_1 = reg_wdata;
                dxcr_pkg::IDX_LINK_PINS: begin
                    // Read-only level bits keep their storage untouched
                    s_d.regs.link_pins[7:6] = reg_wdata[7:6];
                    s_d.regs.link_pins[3:0] = reg_wdata[3:0];
                end
                dxcr_pkg::IDX_TV_CTRL: s_d.regs.tv_ctrl = reg_wdata;
                default: begin
                    // Unmapped index: write ignored
                end
            endcase
        end
        // Read data is captured so it comes from a flop
        if (reg_rd) begin
            case (reg_index)
                dxcr_pkg::IDX_CURSOR_COLOR1_C: s_d.rdata = s_q.regs.cursor_color1_c;
                dxcr_pkg::IDX_CURSOR_LOC_0: s_d.rdata = s_q.regs.cursor_loc_0;
                dxcr_pkg::IDX_CURSOR_LOC_1: s_d.rdata = s_q.regs.cursor_loc_1;
                dxcr_pkg::IDX_CURSOR_LOC_2: s_d.rdata = s_q.regs.cursor_loc_2;
                dxcr_pkg::IDX_URGENCY_START: s_d.rdata = s_q.regs.urgency_start;
                dxcr_pkg::IDX_LINE_OFS_LO: s_d.rdata = s_q.regs.line_ofs_lo;
                dxcr_pkg::IDX_LINE_OFS_HI: s_d.rdata = s_q.regs.line_ofs_hi;
                dxcr_pkg::IDX_HALF_FIELD: s_d.rdata = s_q.regs.half_field;
                dxcr_pkg::IDX_IMPL_ID: s_d.rdata = dxcr_pkg::IMPL_ID_VALUE;
                dxcr_pkg::IDX_VERSION_ID: s_d.rdata = dxcr_pkg::VERSION_ID_VALUE;
                dxcr_pkg::IDX_DRAM_TIMING: s_d.rdata = s_q.regs.dram_timing;
                dxcr_pkg::IDX_ARB_0: s_d.rdata = s_q.regs.arb_0;
                dxcr_pkg::IDX_ARB_1: s_d.rdata = s_q.regs.arb_1;
                dxcr_pkg::IDX_LINK_PINS: begin
                    // Written value above, true pin level below
                    s_d.rdata = {s_q.regs.link_pins[7:6], s_q.link_sync,
                        s_q.regs.link_pins[3:0]};
                end
                dxcr_pkg::IDX_TV_CTRL: s_d.rdata = s_q.regs.tv_ctrl;
                default: s_d.rdata = dxcr_pkg::RST_ZERO;
            endcase
        end
        // Urgency window: opens at start position, closes with display enable
        if (!display_enable) begin
            s_d.urgent_win = 1'b0;
        end else if (hchar_count == s_q.regs.urgency_start) begin
            s_d.urgent_win = 1'b1;
        end
        // All-ones start means urgent whenever FIFO low, the software escape hatch
        if (s_q.regs.urgency_start == 8'hff) begin
            s_d.fetch_urgent = fifo_below_low;
        end else if (s_d.urgent_win) begin
            s_d.fetch_urgent = fifo_below_low;
        end else begin
            s_d.fetch_urgent = 1'b0;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Offset bytes and cursor bytes are undefined after reset; cleared anyway
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.regs.half_field <= dxcr_pkg::RST_HALF_FIELD;
            s_q.regs.dram_timing <= dxcr_pkg::RST_DRAM_TIMING;
            s_q.regs.link_pins <= dxcr_pkg::RST_LINK_PINS;
            s_q.link_meta <= 2'h3;
            s_q.link_sync <= 2'h3;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Register port outputs
    // ****************************************
    assign reg_rdata = s_q.rdata;
    // Combinational decode of mapped indices
    always_comb begin
        case (reg_index)
            dxcr_pkg::IDX_CURSOR_COLOR1_C, dxcr_pkg::IDX_CURSOR_LOC_0,
            dxcr_pkg::IDX_CURSOR_LOC_1, dxcr_pkg::IDX_CURSOR_LOC_2,
            dxcr_pkg::IDX_URGENCY_START, dxcr_pkg::IDX_LINE_OFS_LO,
            dxcr_pkg::IDX_LINE_OFS_HI, dxcr_pkg::IDX_HALF_FIELD,
            dxcr_pkg::IDX_IMPL_ID, dxcr_pkg::IDX_VERSION_ID,
            dxcr_pkg::IDX_DRAM_TIMING, dxcr_pkg::IDX_ARB_0,
            dxcr_pkg::IDX_ARB_1, dxcr_pkg::IDX_LINK_PINS,
            dxcr_pkg::IDX_TV_CTRL: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Display timing
    // ****************************************
    assign fetch_urgent = s_q.fetch_urgent;
    assign frame_line_offset = {s_q.regs.line_ofs_hi, s_q.regs.line_ofs_lo};
    // No separate enable: the all-ones code switches interlace off
    assign interlace_on = (s_q.regs.half_field != dxcr_pkg::HALF_FIELD_OFF);
    // Mid-line vertical tick only in odd frames of interlaced modes
    assign vert_clock_tick = interlace_on && odd_frame
        && (hchar_count == s_q.regs.half_field);

    // ****************************************
    // DRAM timing decode
    // ****************************************
    assign mem_sel = s_q.regs.dram_timing[dxcr_pkg::MEM_TYPE_HI:dxcr_pkg::MEM_TYPE_LO];
    assign tmpl = s_q.regs.dram_timing[dxcr_pkg::TEMPLATE_HI:dxcr_pkg::TEMPLATE_LO];
    // Templates apply to either memory type alike
    always_comb begin
        // Reserved type codes fall back to fast page mode
        dram_cfg.mem_type = (mem_sel == dxcr_pkg::MEM_EDO) ?
            dxcr_pkg::MEM_EDO : dxcr_pkg::MEM_FPM;
        dram_cfg.cas_to_ras_q = dxcr_pkg::T_CAS_RAS_Q;
        if (tmpl[0]) begin
            dram_cfg.precharge_q = dxcr_pkg::T_PRE_B_Q;
            dram_cfg.ras_to_cas_q = dxcr_pkg::T_PRE_B_Q;
        end else begin
            dram_cfg.precharge_q = dxcr_pkg::T_PRE_A_Q;
            dram_cfg.ras_to_cas_q = dxcr_pkg::T_PRE_A_Q;
        end
        // CAS width only meaningful for fast page mode
        dram_cfg.cas_width_q = s_q.regs.dram_timing[dxcr_pkg::CAS_WIDE_BIT] ?
            dxcr_pkg::CAS_WIDE_Q : dxcr_pkg::CAS_NARROW_Q;
        // Turnaround only meaningful for EDO
        dram_cfg.turnaround = s_q.regs.dram_timing[dxcr_pkg::TURN_BIT] ?
            dxcr_pkg::TURN_LONG : dxcr_pkg::TURN_SHORT;
        dram_cfg.row_release = s_q.regs.dram_timing[dxcr_pkg::ROW_REL_BIT];
    end

    // ****************************************
    // Monitor link pins
    // ****************************************
    // Open collector: only ever drive low; a one releases the pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_link
            assign link_pin_o[gi] = 1'b0;
            assign link_pin_oe[gi] = ~s_q.regs.link_pins[dxcr_pkg::LINK_WR_LO + gi];
        end
    endgenerate

    // ****************************************
    // TV output control
    // ****************************************
    // TV bit overrides the video port's own direction bit
    always_comb begin
        if (s_q.regs.tv_ctrl[dxcr_pkg::TV_FIELD_OE_BIT]) begin
            field_src = dxcr_pkg::DXCR_PIN_TV;
        end else if (video_field_dir) begin
            field_src = dxcr_pkg::DXCR_PIN_VIDEO;
        end else begin
            field_src = dxcr_pkg::DXCR_PIN_IN;
        end
        if (s_q.regs.tv_ctrl[dxcr_pkg::TV_SYNC_OE_BIT]) begin
            sync_src = dxcr_pkg::DXCR_PIN_TV;
        end else if (video_sync_dir) begin
            sync_src = dxcr_pkg::DXCR_PIN_VIDEO;
        end else begin
            sync_src = dxcr_pkg::DXCR_PIN_IN;
        end
    end

    // Pin drive from the selected timing generator
    always_comb begin
        case (field_src)
            dxcr_pkg::DXCR_PIN_TV: field_parity_pin_o = tv_field_gen;
            dxcr_pkg::DXCR_PIN_VIDEO: field_parity_pin_o = video_field_gen;
            default: field_parity_pin_o = 1'b0;
        endcase
        case (sync_src)
            dxcr_pkg::DXCR_PIN_TV: tv_line_sync_pin_o = tv_sync_gen;
            dxcr_pkg::DXCR_PIN_VIDEO: tv_line_sync_pin_o = video_sync_gen;
            default: tv_line_sync_pin_o = 1'b0;
        endcase
    end
    assign field_parity_pin_oe = (field_src != dxcr_pkg::DXCR_PIN_IN);
    assign tv_line_sync_pin_oe = (sync_src != dxcr_pkg::DXCR_PIN_IN);

    // Settings handed to the TV encoder; only timing codes gated by the enable
    always_comb begin
        tv_cfg.enable = s_q.regs.tv_ctrl[dxcr_pkg::TV_EN_BIT];
        tv_cfg.timing_codes = tv_cfg.enable
            && s_q.regs.tv_ctrl[dxcr_pkg::TV_CODES_BIT];
        tv_cfg.from_graphics = s_q.regs.tv_ctrl[dxcr_pkg::TV_SRC_N_BIT];
        tv_cfg.field_src = field_src;
        tv_cfg.sync_src = sync_src;
        // Low two bits zero means bypass whatever the luma bit says
        case (s_q.regs.tv_ctrl[dxcr_pkg::FLICK_HI:dxcr_pkg::FLICK_LO])
            2'h1: tv_cfg.filter = dxcr_pkg::DXCR_FLT_011;
            2'h2: tv_cfg.filter = dxcr_pkg::DXCR_FLT_121;
            2'h3: tv_cfg.filter = dxcr_pkg::DXCR_FLT_131;
            default: tv_cfg.filter = dxcr_pkg::DXCR_FLT_OFF;
        endcase
        tv_cfg.luma_only = s_q.regs.tv_ctrl[dxcr_pkg::FLICK_LUMA_BIT]
            && (tv_cfg.filter != dxcr_pkg::DXCR_FLT_OFF);
    end

    // Output port mux; idle stream is zero while disabled
    always_comb begin
        if (!tv_cfg.enable) begin
            tv_pixel = 16'h0000;
        end else if (tv_cfg.from_graphics) begin
            tv_pixel = gfx_pixel;
        end else begin
            tv_pixel = video_pixel;
        end
    end

endmodule

// [verif/dxcr_regs_sva.sv]
// ****************************************
// Port checker for the register bank
// ****************************************
module dxcr_regs_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    input wire logic fifo_below_low,
    input wire logic odd_frame,
    input wire logic fetch_urgent,
    input wire logic vert_clock_tick,
    input wire logic interlace_on,
    input wire logic [1:0] link_pin_o,
    input wire logic [1:0] link_pin_oe,
    input wire dxcr_pkg::dxcr_tv_s tv_cfg,
    input wire logic [15:0] gfx_pixel,
    input wire logic [15:0] video_pixel,
    input wire logic [15:0] tv_pixel,
    input wire logic tv_field_gen,
    input wire logic video_sync_gen,
    input wire logic field_parity_pin_o,
    input wire logic field_parity_pin_oe,
    input wire logic tv_line_sync_pin_o,
    input wire logic tv_line_sync_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff reset;
    // A write to the TV control index
    sequence s_tv_write;
        clk_en && reg_wr && reg_index == dxcr_pkg::IDX_TV_CTRL;
    endsequence
    // Urgency is only ever raised by a low FIFO; frozen cycles skipped
    a_urgent_cause: assert property ($past(clk_en) && fetch_urgent |-> $past(fifo_below_low))
        else $error("urgent fetch without low FIFO");
    a_tick_cause: assert property (vert_clock_tick |-> odd_frame && interlace_on)
        else $error("vertical tick outside odd interlaced frame");
    a_link_low: assert property (link_pin_o == 2'h0)
        else $error("link pin driven high");
    a_link_reset: assert property ($past(reset) |-> link_pin_oe == 2'h0)
        else $error("link pin driven after reset");
    a_tv_off: assert property (!tv_cfg.enable |-> tv_pixel == 16'h0)
        else $error("TV pixels while disabled");
    a_tv_source: assert property (tv_cfg.enable |->
        tv_pixel == (tv_cfg.from_graphics ? gfx_pixel : video_pixel))
        else $error("TV pixel source wrong");
    a_field_tv: assert property (tv_cfg.field_src == dxcr_pkg::DXCR_PIN_TV |->
        field_parity_pin_oe && field_parity_pin_o == tv_field_gen)
        else $error("field pin not from TV generator");
    a_sync_video: assert property (tv_cfg.sync_src == dxcr_pkg::DXCR_PIN_VIDEO |->
        tv_line_sync_pin_oe && tv_line_sync_pin_o == video_sync_gen)
        else $error("line sync pin not from video generator");
    a_tv_write: assert property (s_tv_write |=> tv_cfg.enable == $past(reg_wdata[7])
        && tv_cfg.timing_codes == $past(reg_wdata[7] && reg_wdata[6]))
        else $error("TV control write not applied");
endmodule

bind dxcr_regs dxcr_regs_sva u_sva (.clk, .reset, .clk_en, .reg_wr, .reg_index, .reg_wdata,
    .fifo_below_low, .odd_frame, .fetch_urgent, .vert_clock_tick, .interlace_on, .link_pin_o,
    .link_pin_oe, .tv_cfg, .gfx_pixel, .video_pixel, .tv_pixel, .tv_field_gen, .video_sync_gen,
    .field_parity_pin_o, .field_parity_pin_oe, .tv_line_sync_pin_o, .tv_line_sync_pin_oe);

// [verif/tb_dxcr_regs.sv]
module tb_dxcr_regs;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_hit, fetch_urgent;
    logic [7:0] reg_index = 0, reg_wdata = 0, hchar_count = 0, reg_rdata, v;
    logic display_enable = 0, fifo_below_low = 0, odd_frame = 0, vert_clock_tick, interlace_on;
    logic video_field_dir = 0, video_sync_dir = 0, tv_field_gen = 0, tv_sync_gen = 0;
    logic video_field_gen = 0, video_sync_gen = 0, field_parity_pin_o, field_parity_pin_oe;
    logic tv_line_sync_pin_o, tv_line_sync_pin_oe;
    logic [1:0] link_pin_o, link_pin_oe, link_pin_i, pull_n = 2'h3; // Far device pulls low
    logic [15:0] frame_line_offset, tv_pixel, gfx_pixel = 16'ha5c3, video_pixel = 16'h3c5a;
    dxcr_pkg::dxcr_dram_s dram_cfg;
    dxcr_pkg::dxcr_tv_s tv_cfg;
    int miscompares = 0, num_checks = 0;
    // Open-drain wire: pulled up unless either side pulls low
    assign link_pin_i = ~link_pin_oe & pull_n;
    always #5 clk = ~clk;
    dxcr_regs u_dxcr_regs (.clk, .reset, .clk_en, .reg_wr, .reg_rd, .reg_index, .reg_wdata,
        .reg_rdata, .reg_hit, .hchar_count, .display_enable, .fifo_below_low, .odd_frame,
        .fetch_urgent, .vert_clock_tick, .interlace_on, .frame_line_offset, .dram_cfg,
        .link_pin_o, .link_pin_oe, .link_pin_i, .tv_cfg, .video_field_dir, .video_sync_dir,
        .tv_field_gen, .tv_sync_gen, .video_field_gen, .video_sync_gen, .field_parity_pin_o,
        .field_parity_pin_oe, .tv_line_sync_pin_o, .tv_line_sync_pin_oe, .gfx_pixel,
        .video_pixel, .tv_pixel);
    // ****************************************
    // Access tasks, each returning 1 ns after an edge
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        reg_wr = 1;
        reg_index = idx;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 0;
        // One idle edge so a following call never re-raises the strobe in this step
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        reg_rd = 1;
        reg_index = idx;
        @(posedge clk);
        #1 reg_rd = 0;
        chk(reg_rdata, exp);
        @(posedge clk);
        #1;
    endtask
    // Urgency is registered, so it is judged one edge later
    task automatic urg(input logic de, input logic [7:0] hc, input logic lo, input logic exp);
        display_enable = de;
        hchar_count = hc;
        fifo_below_low = lo;
        @(posedge clk);
        #1 chk(fetch_urgent, exp);
    endtask
    function automatic logic [9:0] tv_exp(input logic [7:0] c, input logic fd, input logic sd);
        // Codes only while enabled; luma-only means nothing with the filter off
        return {c[7], c[7] & c[6], c[5], c[4] ? 2'h2 : {1'b0, fd}, c[3] ? 2'h2 : {1'b0, sd},
            c[1:0], c[2] & (|c[1:0])};
    endfunction
    task end_of_test;
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        #1 reset = 0;
        rd(8'h39, 8'hff);
        chk(interlace_on, 0);
        rd(8'h3c, 8'h00);
        rd(8'h3f, 8'hff);
        wr(8'h3a, 8'h00);
        rd(8'h3a, dxcr_pkg::IMPL_ID_VALUE);
        rd(8'h3b, dxcr_pkg::VERSION_ID_VALUE);
        rd(8'h50, 8'h00);
        chk(reg_hit, 0);
        for (int i = 0; i < 4; i++) wr(8'h2f + 8'(i), 8'h61 + 8'(i));
        for (int i = 0; i < 4; i++) rd(8'h2f + 8'(i), 8'h61 + 8'(i));
        wr(8'h34, 8'h80);
        wr(8'h35, 8'hfe);
        chk(frame_line_offset, 16'hfe80);
        wr(8'h3c, 8'h4f);
        chk(dram_cfg, {dxcr_pkg::MEM_EDO, dxcr_pkg::T_CAS_RAS_Q, dxcr_pkg::T_PRE_B_Q,
            dxcr_pkg::T_PRE_B_Q, dxcr_pkg::CAS_WIDE_Q, dxcr_pkg::TURN_LONG, 1'b1});
        wr(8'h3c, 8'h80);
        chk(dram_cfg, {dxcr_pkg::MEM_FPM, dxcr_pkg::T_CAS_RAS_Q, dxcr_pkg::T_PRE_A_Q,
            dxcr_pkg::T_PRE_A_Q, dxcr_pkg::CAS_NARROW_Q, dxcr_pkg::TURN_SHORT, 1'b0});
        wr(8'h3d, 8'h00);
        clk_en = 0;
        wr(8'h3d, 8'h55);
        clk_en = 1;
        rd(8'h3d, 8'h00);
        wr(8'h3f, 8'h0f);
        chk(link_pin_oe, 2'h3);
        repeat (3) @(posedge clk);
        rd(8'h3f, 8'h0f);
        wr(8'h3f, 8'hff);
        pull_n = 2'h1;
        repeat (3) @(posedge clk);
        rd(8'h3f, 8'hdf);
        wr(8'h33, 8'h10);
        urg(1, 8'h0f, 1, 0);
        urg(1, 8'h10, 1, 1);
        urg(1, 8'h11, 0, 0);
        urg(1, 8'h12, 1, 1);
        urg(0, 8'h12, 1, 0);
        wr(8'h33, 8'hff);
        urg(0, 8'h00, 1, 1);
        wr(8'h39, 8'h20);
        odd_frame = 1;
        hchar_count = 8'h20;
        #1 chk(vert_clock_tick, 1);
        hchar_count = 8'h21;
        #1 chk(vert_clock_tick, 0);
        wr(8'h39, 8'hff);
        hchar_count = 8'hff;
        #1 chk({interlace_on, vert_clock_tick}, 2'h0);
        // Every filter code, both sources, all pin direction cases
        for (int i = 0; i < 8; i++) begin
            v = {i[0], ~i[0], i[1], i[2], i[0] ^ i[1], i[2:0]};
            video_field_dir = i[1];
            video_sync_dir = i[2];
            tv_field_gen = i[0];
            video_sync_gen = ~i[0];
            wr(8'h40, v);
            chk(tv_cfg, tv_exp(v, i[1], i[2]));
            chk(tv_pixel, v[7] ? (v[5] ? gfx_pixel : video_pixel) : 16'h0);
            chk({field_parity_pin_oe, tv_line_sync_pin_oe}, {v[4] | i[1], v[3] | i[2]});
        end
        end_of_test();
    end
endmodule
